// [logic/rx_steer_pkg.sv]
// register map, field layout and reset values for the receive steering block
// assumes a 32-bit word-addressed register bus, byte addresses on the port
package rx_steer_pkg;
  localparam int unsigned addr_width = 4;
  localparam int unsigned data_width = 32;
  localparam int unsigned num_chan = 8;
  localparam int unsigned chan_width = 3;
  localparam logic [addr_width-1:0] group_steer_ctrl_addr = 4'h0;
  localparam logic [addr_width-1:0] ucast_set_addr = 4'h4;
  localparam logic [addr_width-1:0] ucast_clr_addr = 4'h8;
  localparam int unsigned bcast_accept_bit = 13;
  localparam int unsigned bcast_chan_lsb = 8;
  localparam int unsigned mcast_accept_bit = 5;
  localparam int unsigned mcast_chan_lsb = 0;
  localparam logic [data_width-1:0] group_steer_ctrl_mask = 32'h0000_2727;
  localparam logic [data_width-1:0] group_steer_ctrl_reset = 32'h0000_0000;
  localparam logic [num_chan-1:0] ucast_reset = 8'h00;
  localparam logic [data_width-1:0] unmapped_read = 32'h0000_0000;
  typedef enum logic [1:0] {
    frame_none_type,
    frame_ucast_type,
    frame_mcast_type,
    frame_bcast_type
  } frame_class_type;
endpackage : rx_steer_pkg

// [logic/rx_steer_regs.sv]
// register bank: group steering control word and per-channel unicast enables
// assumes writes are pre-decoded one-cycle strobes from the bus slave
`timescale 1ns/100ps
module rx_steer_regs (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ctrl_wr,
  input wire logic i_set_wr,
  input wire logic i_clr_wr,
  input wire logic [rx_steer_pkg::data_width-1:0] i_wdata,
  output logic [rx_steer_pkg::data_width-1:0] o_ctrl,
  output logic [rx_steer_pkg::num_chan-1:0] o_ucast_on
);
  import rx_steer_pkg::*;
  logic [data_width-1:0] ctrl_q;
  logic [data_width-1:0] ctrl_d;
  logic [num_chan-1:0] ucast_q;
  logic [num_chan-1:0] ucast_d;
  logic [num_chan-1:0] set_bits;
  logic [num_chan-1:0] clr_bits;

  assign ctrl_d = i_ctrl_wr ? (i_wdata & group_steer_ctrl_mask) : ctrl_q;
  assign set_bits = i_set_wr ? i_wdata[num_chan-1:0] : '0; // [RULE5]
  assign clr_bits = i_clr_wr ? i_wdata[num_chan-1:0] : '0; // [RULE9]
  // set takes priority if both land in one cycle
  assign ucast_d = (ucast_q & ~clr_bits) | set_bits; // [RULE5] [RULE9]

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_q <= group_steer_ctrl_reset;
      ucast_q <= ucast_reset; // [RULE6]
    end else begin
      ctrl_q <= ctrl_d;
      ucast_q <= ucast_d;
    end
  end

  assign o_ctrl = ctrl_q;
  assign o_ucast_on = ucast_q;

  a_set_takes_bit: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE5]
    i_set_wr |=> ((ucast_q & $past(i_wdata[num_chan-1:0])) == $past(i_wdata[num_chan-1:0])))
    else $error("unicast set write did not set bits");
  a_zero_keeps_bit: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE5]
    (i_set_wr && !i_clr_wr) |=> ((ucast_q & $past(ucast_q)) == $past(ucast_q)))
    else $error("unicast set write cleared a bit");
  a_clr_drops_bit: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE9]
    (i_clr_wr && !i_set_wr) |=> ((ucast_q & $past(i_wdata[num_chan-1:0])) == '0))
    else $error("unicast clear write left a bit set");
  a_reset_clears_en: assert property (@(posedge i_sys_clk) // [RULE6]
    i_rst |=> (ucast_q == ucast_reset))
    else $error("unicast enables not cleared by reset");
endmodule : rx_steer_regs

// [logic/rx_steer_top.sv]
// receive steering: broadcast/multicast accept and channel select, unicast gating
// assumes an Avalon-MM master and a classified frame strobe from the address filter
// Function
// RULE1 - broadcast frames are dropped when broadcast accept is 0 and sent to the broadcast channel when 1.
// RULE2 - bits 10 to 8 hold the broadcast channel, values 0 to 7 naming channels 0 to 7.
// RULE3 - bit 5 enables delivery of hash-matched multicast frames, otherwise they are dropped.
// RULE4 - bits 2 to 0 hold the multicast channel, values 0 to 7 naming channels 0 to 7.
// RULE5 - writing 1 to a bit of the unicast set register turns that channel on, 0 leaves it.
// RULE6 - reading the unicast set register gives the enables, which reset to 0.
// RULE7 - bits 31 to 8 of the unicast set register read 0 and ignore writes.
// RULE8 - broadcast accept sits at bit 13 of the group steering control register.
// RULE9 - writing 1 to a bit of the unicast clear register turns that channel off, 0 leaves it.
// RULE10 - a matched unicast frame goes to its channel only while that channel is enabled.
`timescale 1ns/100ps
module rx_steer_top (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [rx_steer_pkg::addr_width-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [rx_steer_pkg::data_width-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [rx_steer_pkg::data_width-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_frame_valid,
  input wire rx_steer_pkg::frame_class_type i_frame_class,
  input wire logic i_frame_hash_hit,
  input wire logic [rx_steer_pkg::chan_width-1:0] i_frame_ucast_chan,
  output logic o_deliver_valid,
  output logic o_discard_valid,
  output logic [rx_steer_pkg::chan_width-1:0] o_deliver_chan
);
  import rx_steer_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // true when a bus address selects the given register word
  function automatic logic addr_is(
    input logic [addr_width-1:0] addr,
    input logic [addr_width-1:0] reg_addr
  );
    addr_is = (addr == reg_addr);
  endfunction : addr_is

  // three-bit channel number out of a control word
  function automatic logic [chan_width-1:0] chan_field(
    input logic [data_width-1:0] word,
    input int unsigned lsb
  );
    chan_field = word[lsb +: chan_width];
  endfunction : chan_field

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer on the second cycle of a request
  logic ack_q;
  logic ack_d;
  logic [data_width-1:0] rdata_q;
  logic [data_width-1:0] rdata_d;
  wire req = i_avs_read | i_avs_write;
  wire full_word = &i_avs_byteenable;
  // a write lands only at the edge that completes the request
  wire wr_go = i_avs_write & ack_q & full_word;
  wire sel_ctrl = addr_is(i_avs_address, group_steer_ctrl_addr);
  wire sel_set = addr_is(i_avs_address, ucast_set_addr);
  wire sel_clr = addr_is(i_avs_address, ucast_clr_addr);
  logic [data_width-1:0] ctrl;
  logic [num_chan-1:0] ucast_on;
  logic [data_width-1:0] read_mux;

  assign ack_d = req & ~ack_q;
  assign read_mux = sel_ctrl ? ctrl :
                    sel_set ? {{(data_width-num_chan){1'b0}}, ucast_on} : // [RULE6] [RULE7]
                    unmapped_read;
  assign rdata_d = (i_avs_read & ~ack_q) ? read_mux : rdata_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_avs_waitrequest = req & ~ack_q;
  assign o_avs_readdata = rdata_q;

  // bus checks
  a_bus_one_wait: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ($rose(req) || (req && $past(ack_q)))
      |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  a_bus_idle_nowait: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !req |-> !o_avs_waitrequest)
    else $error("waitrequest raised with no request");

  a_ack_single: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ack_q |=> !ack_q)
    else $error("bus answer held for more than one cycle");

  a_bus_write_once: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_go |=> !wr_go)
    else $error("one bus write applied twice");

  a_write_at_done: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_go |-> (i_avs_write && !o_avs_waitrequest))
    else $error("register write before the bus answer");

  a_read_data_holds: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !(i_avs_read && o_avs_waitrequest)
      |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");

  a_unmapped_read_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && !sel_ctrl && !sel_set)
      |=> (o_avs_readdata == unmapped_read))
    else $error("unmapped or clear register read not zero");

  a_ctrl_reads_back: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && sel_ctrl)
      |=> (o_avs_readdata == $past(ctrl)))
    else $error("control register readback wrong");

  a_set_reads_back: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE6] [RULE7]
    (i_avs_read && o_avs_waitrequest && sel_set)
      |=> (o_avs_readdata[data_width-1:num_chan] == '0 && o_avs_readdata[num_chan-1:0] == $past(ucast_on)))
    else $error("unicast set readback wrong");

  a_readdata_reset: assert property (@(posedge i_sys_clk)
    i_rst |=> (o_avs_readdata == '0))
    else $error("read data not cleared by reset");

  ////////////////////////////////////////////////////////////////////////
  // register bank
  rx_steer_regs u_regs (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ctrl_wr(wr_go & sel_ctrl),
    .i_set_wr(wr_go & sel_set), // [RULE7]
    .i_clr_wr(wr_go & sel_clr),
    .i_wdata(i_avs_writedata),
    .o_ctrl(ctrl),
    .o_ucast_on(ucast_on)
  );

  // register checks
  a_ctrl_reset_zero: assert property (@(posedge i_sys_clk)
    i_rst |=> (ctrl == group_steer_ctrl_reset))
    else $error("control register not cleared by reset");

  a_ctrl_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (ctrl & ~group_steer_ctrl_mask) == '0)
    else $error("reserved control bits not zero");

  a_bcast_bit_pos: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE8]
    (wr_go && sel_ctrl) |=> (ctrl[13] == $past(i_avs_writedata[13])))
    else $error("broadcast accept bit not stored at bit 13");

  a_bcast_chan_store: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE2]
    (wr_go && sel_ctrl) |=> (ctrl[10:8] == $past(i_avs_writedata[10:8])))
    else $error("broadcast channel not stored at bits 10 to 8");

  a_mcast_bit_store: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE3]
    (wr_go && sel_ctrl) |=> (ctrl[5] == $past(i_avs_writedata[5])))
    else $error("multicast accept bit not stored at bit 5");

  a_mcast_chan_store: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE4]
    (wr_go && sel_ctrl) |=> (ctrl[2:0] == $past(i_avs_writedata[2:0])))
    else $error("multicast channel not stored at bits 2 to 0");

  a_ctrl_holds: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !(wr_go && sel_ctrl) |=> $stable(ctrl))
    else $error("control register changed without a write");

  a_ucast_holds: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE5] [RULE9]
    !(wr_go && (sel_set || sel_clr)) |=> $stable(ucast_on))
    else $error("unicast enables changed without a write");

  a_set_ors_bits: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE5] [RULE7]
    (wr_go && sel_set)
      |=> (ucast_on == ($past(ucast_on) | $past(i_avs_writedata[num_chan-1:0]))))
    else $error("unicast set write gave wrong enables");

  a_clr_masks_bits: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE9]
    (wr_go && sel_clr)
      |=> (ucast_on == ($past(ucast_on) & ~$past(i_avs_writedata[num_chan-1:0]))))
    else $error("unicast clear write gave wrong enables");

  a_partial_write_ignored: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_avs_write && !full_word) |=> ($stable(ctrl) && $stable(ucast_on)))
    else $error("partial write changed a register");

  ////////////////////////////////////////////////////////////////////////
  // steering decision
  wire bcast_accept_en = ctrl[bcast_accept_bit]; // [RULE8]
  wire [chan_width-1:0] bcast_dest_chan = chan_field(ctrl, bcast_chan_lsb); // [RULE2]
  wire mcast_accept_en = ctrl[mcast_accept_bit]; // [RULE3]
  wire [chan_width-1:0] mcast_dest_chan = chan_field(ctrl, mcast_chan_lsb); // [RULE4]
  logic accept;
  logic [chan_width-1:0] chan_sel;
  logic dvalid_q;
  logic dvalid_d;
  logic discard_q;
  logic discard_d;
  logic [chan_width-1:0] chan_q;
  logic [chan_width-1:0] chan_d;

  always_comb begin
    accept = 1'b0;
    chan_sel = '0;
    unique case (i_frame_class)
      frame_bcast_type: begin
        accept = bcast_accept_en; // [RULE1]
        chan_sel = bcast_dest_chan; // [RULE1] [RULE2]
      end
      frame_mcast_type: begin
        accept = mcast_accept_en & i_frame_hash_hit; // [RULE3]
        chan_sel = mcast_dest_chan; // [RULE4]
      end
      frame_ucast_type: begin
        accept = ucast_on[i_frame_ucast_chan]; // [RULE10]
        chan_sel = i_frame_ucast_chan;
      end
      frame_none_type: begin
        accept = 1'b0;
        chan_sel = '0;
      end
    endcase
  end

  assign dvalid_d = i_frame_valid & accept;
  assign discard_d = i_frame_valid & ~accept;
  assign chan_d = dvalid_d ? chan_sel : chan_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dvalid_q <= 1'b0;
      discard_q <= 1'b0;
      chan_q <= '0;
    end else begin
      dvalid_q <= dvalid_d;
      discard_q <= discard_d;
      chan_q <= chan_d;
    end
  end

  assign o_deliver_valid = dvalid_q;
  assign o_discard_valid = discard_q;
  assign o_deliver_chan = chan_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_bcast_drop_off: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE1]
    (i_frame_valid && i_frame_class == frame_bcast_type && !ctrl[bcast_accept_bit])
      |=> (o_discard_valid && !o_deliver_valid))
    else $error("broadcast frame not discarded while disabled");

  a_bcast_to_chan: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE1] [RULE2]
    (i_frame_valid && i_frame_class == frame_bcast_type && ctrl[bcast_accept_bit])
      |=> (o_deliver_valid && o_deliver_chan == $past(ctrl[10:8])))
    else $error("broadcast frame sent to wrong channel");

  a_mcast_gate_hit: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE3]
    (i_frame_valid && i_frame_class == frame_mcast_type)
      |=> (o_deliver_valid == $past(ctrl[5] && i_frame_hash_hit)))
    else $error("multicast accept decision wrong");

  a_mcast_miss_drop: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE3]
    (i_frame_valid && i_frame_class == frame_mcast_type && !i_frame_hash_hit) |=> o_discard_valid)
    else $error("multicast frame without hash hit not discarded");

  a_mcast_to_chan: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE4]
    (i_frame_valid && i_frame_class == frame_mcast_type && ctrl[5] && i_frame_hash_hit)
      |=> (o_deliver_chan == $past(ctrl[2:0])))
    else $error("multicast frame sent to wrong channel");

  a_ucast_gate_en: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE10]
    (i_frame_valid && i_frame_class == frame_ucast_type)
      |=> (o_deliver_valid == $past(ucast_on[i_frame_ucast_chan])))
    else $error("unicast gating wrong");

  a_ucast_off_drop: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE10]
    (i_frame_valid && i_frame_class == frame_ucast_type && !ucast_on[i_frame_ucast_chan])
      |=> (o_discard_valid && !o_deliver_valid))
    else $error("unicast frame on a disabled channel not discarded");

  a_ucast_to_chan: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE10]
    (i_frame_valid && i_frame_class == frame_ucast_type && ucast_on[i_frame_ucast_chan])
      |=> (o_deliver_valid && o_deliver_chan == $past(i_frame_ucast_chan)))
    else $error("unicast frame sent to wrong channel");

  a_one_answer_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_frame_valid |=> (o_deliver_valid != o_discard_valid))
    else $error("frame not answered by exactly one decision");

  a_no_stray_answer: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_frame_valid |=> (!o_deliver_valid && !o_discard_valid))
    else $error("decision without a frame");

  a_none_class_dropped: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_frame_valid && i_frame_class == frame_none_type) |=> o_discard_valid)
    else $error("unclassified frame not discarded");

  a_chan_holds: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !dvalid_d |=> $stable(o_deliver_chan))
    else $error("delivery channel changed without a delivery");

  a_frame_outs_reset: assert property (@(posedge i_sys_clk)
    i_rst |=> (!o_deliver_valid && !o_discard_valid && o_deliver_chan == '0))
    else $error("frame decision outputs not cleared by reset");
endmodule : rx_steer_top

// [tb/tb_top.sv]
// self-checking bench for the receive steering block: registers over the bus, then frame decisions
// assumes rx_steer_pkg and rx_steer_top are compiled first; one clock, synchronous reset
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
  import rx_steer_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [addr_width-1:0] i_avs_address = '0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [data_width-1:0] i_avs_writedata = '0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic [data_width-1:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic i_frame_valid = 1'b0;
  frame_class_type i_frame_class = frame_none_type;
  logic i_frame_hash_hit = 1'b0;
  logic [chan_width-1:0] i_frame_ucast_chan = '0;
  logic o_deliver_valid;
  logic o_discard_valid;
  logic [chan_width-1:0] o_deliver_chan;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [data_width-1:0] rd;

  rx_steer_top i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_frame_valid(i_frame_valid), .i_frame_class(i_frame_class),
    .i_frame_hash_hit(i_frame_hash_hit), .i_frame_ucast_chan(i_frame_ucast_chan),
    .o_deliver_valid(o_deliver_valid), .o_discard_valid(o_discard_valid), .o_deliver_chan(o_deliver_chan));

  always #2.5 i_sys_clk = ~i_sys_clk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // one bus transfer, held until waitrequest is sampled low
  task bus_xfer(input logic is_rd, input logic [addr_width-1:0] a, input logic [data_width-1:0] d,
                input logic [3:0] be);
    @(posedge i_sys_clk);
    i_avs_read <= is_rd;
    i_avs_write <= ~is_rd;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus_xfer

  task wr(input logic [addr_width-1:0] a, input logic [data_width-1:0] d);
    bus_xfer(1'b0, a, d, 4'hF);
  endtask : wr

  task rd_reg(input logic [addr_width-1:0] a);
    bus_xfer(1'b1, a, 32'h0000_0000, 4'hF);
  endtask : rd_reg

  // one frame pulse; the decision is judged in the cycle after it
  task frame(input frame_class_type c, input logic hit, input logic [2:0] uc, input logic del, input logic [2:0] ch);
    @(posedge i_sys_clk);
    i_frame_valid <= 1'b1;
    i_frame_class <= c;
    i_frame_hash_hit <= hit;
    i_frame_ucast_chan <= uc;
    @(posedge i_sys_clk);
    i_frame_valid <= 1'b0;
    @(negedge i_sys_clk);
    `CHK({o_deliver_valid, o_discard_valid}, {del, ~del})
    if (del) `CHK(o_deliver_chan, ch)
  endtask : frame

  //////////////////////////////////////////////////////////////////////////////
  task t_reset_vals;
    rd_reg(group_steer_ctrl_addr);
    `CHK(rd, 32'h0000_0000)
    rd_reg(ucast_set_addr);
    `CHK(rd, 32'h0000_0000)
  endtask : t_reset_vals

  task t_bcast;
    wr(group_steer_ctrl_addr, 32'hFFFF_FFFF);
    rd_reg(group_steer_ctrl_addr);
    `CHK(rd, 32'h0000_2727)
    for (int c = 0; c < 8; c++) begin
      wr(group_steer_ctrl_addr, {18'h0, 1'b1, 2'b00, c[2:0], 8'h00});
      frame(frame_bcast_type, 1'b0, 3'h0, 1'b1, c[2:0]);
      frame(frame_mcast_type, 1'b1, 3'h0, 1'b0, 3'h0);
    end
    wr(group_steer_ctrl_addr, 32'h0000_0727);
    frame(frame_bcast_type, 1'b0, 3'h0, 1'b0, 3'h0);
  endtask : t_bcast

  task t_mcast;
    for (int c = 0; c < 8; c++) begin
      wr(group_steer_ctrl_addr, {26'h0, 1'b1, 2'b00, c[2:0]});
      frame(frame_mcast_type, 1'b1, 3'h0, 1'b1, c[2:0]);
    end
    frame(frame_mcast_type, 1'b0, 3'h0, 1'b0, 3'h0);
    frame(frame_bcast_type, 1'b0, 3'h0, 1'b0, 3'h0);
  endtask : t_mcast

  task t_ucast;
    wr(ucast_set_addr, 32'hFFFF_FF05);
    rd_reg(ucast_set_addr);
    `CHK(rd, 32'h0000_0005)
    wr(ucast_set_addr, 32'h0000_0000);
    wr(ucast_clr_addr, 32'h0000_0001);
    rd_reg(ucast_set_addr);
    `CHK(rd, 32'h0000_0004)
    rd_reg(ucast_clr_addr);
    `CHK(rd, 32'h0000_0000)
    bus_xfer(1'b0, ucast_set_addr, 32'h0000_00FF, 4'h1);
    wr(4'hC, 32'hFFFF_FFFF);
    rd_reg(4'hC);
    `CHK(rd, 32'h0000_0000)
    rd_reg(ucast_set_addr);
    `CHK(rd, 32'h0000_0004)
    frame(frame_ucast_type, 1'b0, 3'h2, 1'b1, 3'h2);
    frame(frame_ucast_type, 1'b0, 3'h0, 1'b0, 3'h0);
    frame(frame_none_type, 1'b1, 3'h2, 1'b0, 3'h0);
  endtask : t_ucast

  task t_reset_mid;
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd_reg(ucast_set_addr);
    `CHK(rd, 32'h0000_0000)
    rd_reg(group_steer_ctrl_addr);
    `CHK(rd, 32'h0000_0000)
    frame(frame_ucast_type, 1'b0, 3'h2, 1'b0, 3'h0);
  endtask : t_reset_mid

  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset_vals();
    t_bcast();
    t_mcast();
    t_ucast();
    t_reset_mid();
    give_verdict();
  end
endmodule : tb_top
